/* File: include/pcm_defines.svh */
// How it works
// - Type field picks quadrature, fwd/rev, step+dir
// - Too-fast pulse activity is discarded as noise
// - Filter codes set low and high cutoffs
// - Source field picks low or high pins
// - Source-select input overrides stored source field
// - Mode codes 00-05 select single modes
// - Codes 06-0A pair modes, input picks
// - Internal position runs 64 stored positions, homing
// - Speed-select inputs choose speed command source
// - Torque-select inputs choose torque command source
// - Zero modes use zero or internal presets
// - Mode change reloads I/O defaults when enabled
// - Speed limit enabled only in torque mode
// - Torque limit only in position, speed modes
// - Limit-enable inputs also activate limits
// - Select inputs choose limit value source
// - Monitor polarity field sets both monitor signs
// - One common polarity for position pulse outputs
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define PCM_IDX_PULSE_IN  12'h100
`define PCM_IDX_CTRL_MODE 12'h102
`define PCM_IDX_LIMIT_EN  12'h104
`define PCM_IDX_OUT_POL   12'h106
`define PCM_IDX_STATUS    12'h108
`define PCM_RST_PULSE_IN  16'h0002
`define PCM_RST_CTRL_MODE 16'h0000
`define PCM_RST_LIMIT_EN  16'h0000
`define PCM_RST_OUT_POL   16'h0000
`define PCM_MAX_PULSE_IN  16'h1142
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCM_F_TYPE    3:0
`define PCM_F_FILT    7:4
`define PCM_F_INPOL   8
`define PCM_F_SRC     12
`define PCM_F_MODE    7:0
`define PCM_F_IORST   12
`define PCM_F_SPDLIM  0
`define PCM_F_TRQLIM  4
`define PCM_F_MONPOL  1:0
`define PCM_F_PULSPOL 4
// ----------------------------------------
// Timing: clock and filter cutoffs (kpps)
// ----------------------------------------
`define PCM_CLK_KHZ 100000
`define PCM_LO_KPPS0 1660
`define PCM_LO_KPPS1 416
`define PCM_LO_KPPS2 208
`define PCM_LO_KPPS3 104
`define PCM_HI_KPPS0 6660
`define PCM_HI_KPPS1 1660
`define PCM_HI_KPPS2 833
`define PCM_HI_KPPS3 416
// Minimum stable half period in cycles, rounded up
`define PCM_HOLD(k) (((`PCM_CLK_KHZ) + 2 * (k) - 1) / (2 * (k)))
`endif

/* File: include/pcm_pkg.sv */
package pcm_pkg;
  typedef enum logic [5:0] {
    PCM_M_EXT_POS  = 6'b000001,
    PCM_M_INT_POS  = 6'b000010,
    PCM_M_SPEED    = 6'b000100,
    PCM_M_TORQUE   = 6'b001000,
    PCM_M_ZERO_SPD = 6'b010000,
    PCM_M_ZERO_TRQ = 6'b100000
  } pcm_mode_t;
  typedef struct packed {
    logic       step;
    logic       dir;
  } pcm_pins_t;
  typedef struct packed {
    logic       inc;
    logic       dec;
  } pcm_count_t;
endpackage : pcm_pkg

/* File: rtl/pcm_filter.sv */
`include "pcm_defines.svh"
// ----------------------------------------
// Glitch filter: an input level is accepted only after it stays stable for the hold count
// ----------------------------------------
module pcm_filter
  import pcm_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [CW-1:0] hold,
  input  wire pcm_pins_t     raw,
  output      pcm_pins_t     clean
);
  pcm_pins_t     last_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= '0;
      cnt_r  <= '0;
      clean  <= '0;
    end else if (raw != last_r) begin
      last_r <= raw;
      cnt_r  <= CW'(1);
    end else if (cnt_r >= hold) begin
      clean  <= last_r;
    end else begin
      cnt_r  <= cnt_r + CW'(1);
    end
  end

  a_filter_stable: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(clean) |-> $past(raw) == clean)
    else $error("filter output changed to an unstable level");
endmodule : pcm_filter

/* File: rtl/pcm_top.sv */
// The APB slave port was left to the implementer.
`include "pcm_defines.svh"
module pcm_top
  import pcm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire pcm_pins_t   low_speed_pins,
  input  wire pcm_pins_t   high_speed_pins,
  input  wire logic        pulse_source_select_assigned,
  input  wire logic        pulse_source_select_input,
  input  wire logic        mode_select_input,
  input  wire logic [5:0]  position_select,
  input  wire logic        speed_select_bit0,
  input  wire logic        speed_select_bit1,
  input  wire logic        torque_select_bit0,
  input  wire logic        torque_select_bit1,
  input  wire logic        speed_limit_enable_input,
  input  wire logic        torque_limit_enable_input,
  output      logic        count_inc,
  output      logic        count_dec,
  output      logic [5:0]  active_mode,
  output      logic        mode_reserved,
  output      logic [5:0]  position_index,
  output      logic        homing_allowed,
  output      logic [1:0]  speed_cmd_source,
  output      logic [1:0]  torque_cmd_source,
  output      logic        speed_cmd_zero,
  output      logic        torque_cmd_zero,
  output      logic        speed_limit_active,
  output      logic        torque_limit_active,
  output      logic [1:0]  speed_limit_source,
  output      logic [1:0]  torque_limit_source,
  output      logic        io_defaults_load,
  output      logic        analog_monitor_first_neg,
  output      logic        analog_monitor_second_neg,
  output      logic        position_pulse_invert
);
  // ----------------------------------------
  // Registers and APB slave
  // ----------------------------------------
  logic [15:0] pulse_in_r;
  logic [15:0] ctrl_mode_r;
  logic [15:0] limit_en_r;
  logic [15:0] out_pol_r;
  logic [11:0] idx;
  logic        hit_valid;
  logic        access;
  logic [15:0] wdata16;
  logic [5:0]  mode_nxt;
  logic [5:0]  mode_prev_r;
  logic        src_sel;

  function automatic logic [11:0] idx_of(input logic [31:0] a);
    idx_of = a[13:2];
  endfunction : idx_of

  function automatic logic is_reg(input logic [11:0] i);
    is_reg = (i == `PCM_IDX_PULSE_IN) || (i == `PCM_IDX_CTRL_MODE) ||
             (i == `PCM_IDX_LIMIT_EN) || (i == `PCM_IDX_OUT_POL) ||
             (i == `PCM_IDX_STATUS);
  endfunction : is_reg

  assign idx       = idx_of(paddr);
  assign hit_valid = is_reg(idx) && (paddr[31:14] == 18'h0) && (paddr[1:0] == 2'h0);
  assign access    = psel && penable;
  assign wdata16   = pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_in_r  <= `PCM_RST_PULSE_IN;
      ctrl_mode_r <= `PCM_RST_CTRL_MODE;
      limit_en_r  <= `PCM_RST_LIMIT_EN;
      out_pol_r   <= `PCM_RST_OUT_POL;
    end else if (access && pwrite && hit_valid) begin
      case (idx)
        `PCM_IDX_PULSE_IN: begin
          if (wdata16 <= `PCM_MAX_PULSE_IN) begin
            pulse_in_r <= wdata16;
          end
        end
        `PCM_IDX_CTRL_MODE: ctrl_mode_r <= wdata16;
        `PCM_IDX_LIMIT_EN:  limit_en_r  <= wdata16;
        `PCM_IDX_OUT_POL:   out_pol_r   <= wdata16;
        default:            ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_valid;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite && hit_valid) begin
        case (idx)
          `PCM_IDX_PULSE_IN:  prdata <= {16'h0, pulse_in_r};
          `PCM_IDX_CTRL_MODE: prdata <= {16'h0, ctrl_mode_r};
          `PCM_IDX_LIMIT_EN:  prdata <= {16'h0, limit_en_r};
          `PCM_IDX_OUT_POL:   prdata <= {16'h0, out_pol_r};
          `PCM_IDX_STATUS:    prdata <= {24'h0, src_sel, mode_reserved, active_mode};
          default:            prdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pcm_pins_t lo_s1_r;
  pcm_pins_t lo_s2_r;
  pcm_pins_t hi_s1_r;
  pcm_pins_t hi_s2_r;
  logic [9:0] di_s1_r;
  logic [9:0] di_s2_r;
  logic [5:0] pos_s1_r;
  logic [5:0] pos_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_s1_r  <= '0;
      lo_s2_r  <= '0;
      hi_s1_r  <= '0;
      hi_s2_r  <= '0;
      di_s1_r  <= 10'h0;
      di_s2_r  <= 10'h0;
      pos_s1_r <= 6'h0;
      pos_s2_r <= 6'h0;
    end else begin
      lo_s1_r  <= low_speed_pins;
      lo_s2_r  <= lo_s1_r;
      hi_s1_r  <= high_speed_pins;
      hi_s2_r  <= hi_s1_r;
      di_s1_r  <= {pulse_source_select_assigned, pulse_source_select_input, mode_select_input,
                   speed_select_bit0, speed_select_bit1, torque_select_bit0, torque_select_bit1,
                   speed_limit_enable_input, torque_limit_enable_input, 1'b0};
      di_s2_r  <= di_s1_r;
      pos_s1_r <= position_select;
      pos_s2_r <= pos_s1_r;
    end
  end

  logic di_src_asg;
  logic di_src;
  logic di_msel;
  logic [1:0] di_spd;
  logic [1:0] di_trq;
  logic di_speed_limit_enable_input;
  logic di_torque_limit_enable_input;
  assign di_src_asg = di_s2_r[9];
  assign di_src     = di_s2_r[8];
  assign di_msel    = di_s2_r[7];
  assign di_spd     = {di_s2_r[5], di_s2_r[6]};
  assign di_trq     = {di_s2_r[3], di_s2_r[4]};
  assign di_speed_limit_enable_input   = di_s2_r[2];
  assign di_torque_limit_enable_input   = di_s2_r[1];

  // ----------------------------------------
  // Pulse source, polarity and filter
  // ----------------------------------------
  pcm_pins_t   sel_pins;
  pcm_pins_t   pol_pins;
  pcm_pins_t   clean;
  logic [15:0] hold;

  assign src_sel  = di_src_asg ? di_src : pulse_in_r[`PCM_F_SRC];
  assign sel_pins = src_sel ? hi_s2_r : lo_s2_r;
  assign pol_pins = pulse_in_r[`PCM_F_INPOL] ? ~sel_pins : sel_pins;

  always_comb begin
    hold = 16'(`PCM_HOLD(`PCM_LO_KPPS0));
    case ({src_sel, pulse_in_r[5:4]})
      3'h0:    hold = 16'(`PCM_HOLD(`PCM_LO_KPPS0));
      3'h1:    hold = 16'(`PCM_HOLD(`PCM_LO_KPPS1));
      3'h2:    hold = 16'(`PCM_HOLD(`PCM_LO_KPPS2));
      3'h3:    hold = 16'(`PCM_HOLD(`PCM_LO_KPPS3));
      3'h4:    hold = 16'(`PCM_HOLD(`PCM_HI_KPPS0));
      3'h5:    hold = 16'(`PCM_HOLD(`PCM_HI_KPPS1));
      3'h6:    hold = 16'(`PCM_HOLD(`PCM_HI_KPPS2));
      default: hold = 16'(`PCM_HOLD(`PCM_HI_KPPS3));
    endcase
  end

  pcm_filter #(.CW(16)) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (hold),
    .raw     (pol_pins),
    .clean   (clean)
  );

  // ----------------------------------------
  // Pulse decoder
  // ----------------------------------------
  pcm_pins_t  prev_r;
  pcm_count_t cnt;

  always_comb begin
    cnt = '0;
    case (pulse_in_r[`PCM_F_TYPE])
      4'h0: begin
        if ((clean.step != prev_r.step) || (clean.dir != prev_r.dir)) begin
          if ((prev_r.step ^ clean.dir) && !(prev_r.dir ^ clean.step)) begin
            cnt.inc = 1'b1;
          end else if (!(prev_r.step ^ clean.dir) && (prev_r.dir ^ clean.step)) begin
            cnt.dec = 1'b1;
          end
        end
      end
      4'h1: begin
        cnt.inc = clean.step && !prev_r.step;
        cnt.dec = clean.dir && !prev_r.dir;
      end
      4'h2: begin
        cnt.inc = clean.step && !prev_r.step && !clean.dir;
        cnt.dec = clean.step && !prev_r.step && clean.dir;
      end
      default: cnt = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r    <= '0;
      count_inc <= 1'b0;
      count_dec <= 1'b0;
    end else begin
      prev_r    <= clean;
      count_inc <= cnt.inc && !cnt.dec;
      count_dec <= cnt.dec && !cnt.inc;
    end
  end

  // ----------------------------------------
  // Control mode decode
  // ----------------------------------------
  function automatic logic [5:0] mode_of(input logic [7:0] code, input logic sel);
    case (code)
      8'h00:   mode_of = PCM_M_EXT_POS;
      8'h01:   mode_of = PCM_M_INT_POS;
      8'h02:   mode_of = PCM_M_SPEED;
      8'h03:   mode_of = PCM_M_TORQUE;
      8'h04:   mode_of = PCM_M_ZERO_SPD;
      8'h05:   mode_of = PCM_M_ZERO_TRQ;
      8'h06:   mode_of = sel ? PCM_M_SPEED  : PCM_M_EXT_POS;
      8'h07:   mode_of = sel ? PCM_M_TORQUE : PCM_M_EXT_POS;
      8'h08:   mode_of = sel ? PCM_M_SPEED  : PCM_M_INT_POS;
      8'h09:   mode_of = sel ? PCM_M_TORQUE : PCM_M_INT_POS;
      8'h0A:   mode_of = sel ? PCM_M_TORQUE : PCM_M_SPEED;
      default: mode_of = 6'h00;
    endcase
  endfunction : mode_of

  assign mode_nxt = mode_of(ctrl_mode_r[`PCM_F_MODE], di_msel);

  logic is_pos;
  logic is_spd;
  logic is_trq;
  assign is_pos = mode_nxt[0] || mode_nxt[1];
  assign is_spd = mode_nxt[2] || mode_nxt[4];
  assign is_trq = mode_nxt[3] || mode_nxt[5];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode      <= 6'h00;
      mode_prev_r      <= 6'h00;
      mode_reserved    <= 1'b0;
      io_defaults_load <= 1'b0;
    end else begin
      active_mode      <= mode_nxt;
      mode_prev_r      <= mode_nxt;
      mode_reserved    <= (mode_nxt == 6'h00);
      io_defaults_load <= ctrl_mode_r[`PCM_F_IORST] && (mode_nxt != mode_prev_r);
    end
  end

  a_iorst_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    io_defaults_load |-> $past(ctrl_mode_r[12]) && ($past(mode_nxt) != $past(mode_prev_r)))
    else $error("I/O default reload without mode change");

  // ----------------------------------------
  // Command sources and limits
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_index      <= 6'h00;
      homing_allowed      <= 1'b0;
      speed_cmd_source    <= 2'h0;
      torque_cmd_source   <= 2'h0;
      speed_cmd_zero      <= 1'b0;
      torque_cmd_zero     <= 1'b0;
      speed_limit_active  <= 1'b0;
      torque_limit_active <= 1'b0;
      speed_limit_source  <= 2'h0;
      torque_limit_source <= 2'h0;
    end else begin
      position_index    <= mode_nxt[1] ? pos_s2_r : 6'h00;
      homing_allowed    <= mode_nxt[1];
      speed_cmd_source  <= is_spd ? di_spd : 2'h0;
      torque_cmd_source <= is_trq ? di_trq : 2'h0;
      speed_cmd_zero    <= mode_nxt[4] && (di_spd == 2'h0);
      torque_cmd_zero   <= mode_nxt[5] && (di_trq == 2'h0);
      speed_limit_active  <= is_trq && (limit_en_r[`PCM_F_SPDLIM] || di_speed_limit_enable_input);
      torque_limit_active <= (is_pos || is_spd) && (limit_en_r[`PCM_F_TRQLIM] || di_torque_limit_enable_input);
      speed_limit_source  <= di_spd;
      torque_limit_source <= di_trq;
    end
  end

  a_spdlim_mode: assert property (@(posedge pclk) disable iff (!presetn)
    speed_limit_active |-> $past(is_trq))
    else $error("speed limit active outside torque mode");
  a_trqlim_mode: assert property (@(posedge pclk) disable iff (!presetn)
    torque_limit_active |-> $past(is_pos || is_spd))
    else $error("torque limit active outside position or speed");
  a_limit_cause: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(is_trq) && $past(di_speed_limit_enable_input)) |-> speed_limit_active)
    else $error("speed limit input ignored");
  a_zero_speed: assert property (@(posedge pclk) disable iff (!presetn)
    speed_cmd_zero |-> $past(mode_nxt[4]) && speed_cmd_source == 2'h0)
    else $error("zero speed command outside zero speed mode");
  a_type_range: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_in_r <= `PCM_MAX_PULSE_IN)
    else $error("pulse input setting out of range");
  a_dir_excl: assert property (@(posedge pclk) disable iff (!presetn)
    !(count_inc && count_dec))
    else $error("both count directions at once");
  a_src_override: assert property (@(posedge pclk) disable iff (!presetn)
    di_src_asg |-> src_sel == di_src)
    else $error("source select input not obeyed");

  // ----------------------------------------
  // Output polarity
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_monitor_first_neg  <= 1'b0;
      analog_monitor_second_neg <= 1'b0;
      position_pulse_invert     <= 1'b0;
    end else begin
      analog_monitor_first_neg  <= out_pol_r[1];
      analog_monitor_second_neg <= out_pol_r[0];
      position_pulse_invert     <= out_pol_r[`PCM_F_PULSPOL];
    end
  end

  a_mon_pol: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 analog_monitor_second_neg == $past(out_pol_r[0]))
    else $error("second monitor polarity wrong");
endmodule : pcm_top

/* File: test/pcm_ctrl_model.sv */
module pcm_ctrl_model
  import pcm_pkg::*;
(
  input  wire logic pclk,
  output pcm_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;

  initial pins = '0;

  task automatic put(input logic [1:0] v, input int h);
    @(posedge pclk);
    pins <= v;
    repeat (h - 1) @(posedge pclk);
  endtask : put

  // Half periods below the legal minimum only when the bench asks for noise
  task automatic send(input int kind, input int n, input int h, input logic fwd);
    logic [7:0] q;
    q = fwd ? 8'h78 : 8'hB4;
    repeat (n) begin
      if (kind == 0) begin
        for (int k = 3; k >= 0; k--) put(q[2*k+:2], h);
      end else begin
        put({1'b0, kind == 2 && !fwd}, h);
        put((kind == 1 && !fwd) ? 2'b01 : {1'b1, kind == 2 && !fwd}, h);
        put({1'b0, kind == 2 && !fwd}, h);
      end
    end
  endtask : send
endmodule : pcm_ctrl_model

/* File: test/pulse_command_mode_config_test.sv */
`include "pcm_defines.svh"
module pulse_command_mode_config_test
  import pcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] A_PI = 32'(4 * `PCM_IDX_PULSE_IN);
  localparam logic [31:0] A_CM = 32'(4 * `PCM_IDX_CTRL_MODE);
  localparam logic [31:0] A_LE = 32'(4 * `PCM_IDX_LIMIT_EN);
  localparam logic [31:0] A_OP = 32'(4 * `PCM_IDX_OUT_POL);
  localparam logic [31:0] A_ST = 32'(4 * `PCM_IDX_STATUS);

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  pcm_pins_t   low_speed_pins, high_speed_pins;
  logic        pulse_source_select_assigned, pulse_source_select_input, mode_select_input;
  logic [5:0]  position_select, active_mode, position_index;
  logic        speed_select_bit0, speed_select_bit1, torque_select_bit0, torque_select_bit1;
  logic        speed_limit_enable_input, torque_limit_enable_input, count_inc, count_dec;
  logic        mode_reserved, homing_allowed, speed_cmd_zero, torque_cmd_zero;
  logic [1:0]  speed_cmd_source, torque_cmd_source, speed_limit_source, torque_limit_source;
  logic        speed_limit_active, torque_limit_active, io_defaults_load;
  logic        analog_monitor_first_neg, analog_monitor_second_neg, position_pulse_invert;
  int          miscompares, num_checks, ninc, ndec, nio;

  pcm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .low_speed_pins, .high_speed_pins, .pulse_source_select_assigned,
    .pulse_source_select_input, .mode_select_input, .position_select, .speed_select_bit0,
    .speed_select_bit1, .torque_select_bit0, .torque_select_bit1, .speed_limit_enable_input,
    .torque_limit_enable_input, .count_inc, .count_dec, .active_mode, .mode_reserved,
    .position_index, .homing_allowed, .speed_cmd_source, .torque_cmd_source, .speed_cmd_zero,
    .torque_cmd_zero, .speed_limit_active, .torque_limit_active, .speed_limit_source,
    .torque_limit_source, .io_defaults_load, .analog_monitor_first_neg,
    .analog_monitor_second_neg, .position_pulse_invert);
  pcm_ctrl_model u_lo (.pclk, .pins(low_speed_pins));
  pcm_ctrl_model u_hi (.pclk, .pins(high_speed_pins));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Pulse counters, sampled mid-cycle
  // ----------------------------------------
  always @(negedge pclk) begin
    if (count_inc === 1'b1) ninc++;
    if (count_dec === 1'b1) ndec++;
    if (io_defaults_load === 1'b1) nio++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [31:0] a, exp, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(e, ee);
  endtask : rdc

  task automatic run(input logic hi, input int kind, n, h, input logic fwd, input int ei, ed);
    int i0, d0;
    repeat (600) @(posedge pclk);
    i0 = ninc;
    d0 = ndec;
    if (hi) u_hi.send(kind, n, h, fwd);
    else u_lo.send(kind, n, h, fwd);
    repeat (600) @(posedge pclk);
    chk(ninc - i0, ei);
    chk(ndec - d0, ed);
  endtask : run

  task automatic setm(input logic [31:0] c);
    wr(A_CM, c);
    repeat (8) @(posedge pclk);
  endtask : setm

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdc(A_PI, 32'h2, 1'b0);
    rdc(A_CM, 32'h0, 1'b0);
    rdc(A_LE, 32'h0, 1'b0);
    rdc(A_OP, 32'h0, 1'b0);
    wr(A_PI, 32'h1142);
    rdc(A_PI, 32'h1142, 1'b0);
    wr(A_PI, 32'h1143);
    rdc(A_PI, 32'h1142, 1'b0);
    wr(A_PI, 32'h2);
    wr(A_CM, 32'h1005);
    rdc(A_CM, 32'h1005, 1'b0);
    wr(A_LE, 32'h11);
    rdc(A_LE, 32'h11, 1'b0);
    wr(A_OP, 32'h13);
    rdc(A_OP, 32'h13, 1'b0);
    rdc(A_ST, 32'h20, 1'b0);
    rdc(32'h424, 32'h0, 1'b1);
    rdc(A_PI + 32'h2, 32'h0, 1'b1);
    $display("register test done");
  endtask : t_regs

  task automatic t_pulses;
    wr(A_PI, 32'h0);
    run(0, 0, 3, 50, 1, 12, 0);
    run(0, 0, 2, 50, 0, 0, 8);
    wr(A_PI, 32'h1);
    run(0, 1, 3, 50, 1, 3, 0);
    run(0, 1, 2, 50, 0, 0, 2);
    wr(A_PI, 32'h2);
    run(0, 2, 3, 50, 1, 3, 0);
    run(0, 2, 2, 50, 0, 0, 2);
    run(0, 2, 3, 10, 1, 0, 0);
    wr(A_PI, 32'h32);
    run(0, 2, 2, 300, 1, 0, 0);
    run(0, 2, 2, 520, 1, 2, 0);
    wr(A_PI, 32'h1002);
    run(1, 2, 3, 12, 1, 3, 0);
    run(0, 2, 3, 50, 1, 0, 0);
    wr(A_PI, 32'h1032);
    run(1, 2, 2, 100, 1, 0, 0);
    wr(A_PI, 32'h0002);
    pulse_source_select_assigned <= 1'b1;
    pulse_source_select_input <= 1'b1;
    run(1, 2, 2, 50, 1, 2, 0);
    pulse_source_select_assigned <= 1'b0;
    wr(A_PI, 32'h0102);
    run(0, 2, 2, 50, 1, 0, 2);
    $display("pulse test done");
  endtask : t_pulses

  task automatic t_modes;
    logic [5:0] m0 [12] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01, 6'h01, 6'h02, 6'h02, 6'h04, 6'h00};
    logic [5:0] m1 [12] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h04, 6'h08, 6'h04, 6'h08, 6'h08, 6'h00};
    int         io0;
    io0 = nio;
    for (int c = 0; c < 12; c++) begin
      for (int s = 0; s < 2; s++) begin
        mode_select_input <= s[0];
        setm(32'(c));
        chk(active_mode, s[0] ? m1[c] : m0[c]);
        chk(mode_reserved, c == 11);
      end
    end
    chk(nio - io0, 0);
    setm(32'h1001);
    chk(nio - io0, 1);
    $display("mode test done");
  endtask : t_modes

  task automatic t_cmds;
    {speed_select_bit1, speed_select_bit0} <= 2'b10;
    {torque_select_bit1, torque_select_bit0} <= 2'b01;
    position_select <= 6'h2A;
    wr(A_LE, 32'h11);
    setm(32'h2);
    chk(speed_cmd_source, 2'h2);
    chk(torque_cmd_source, 2'h0);
    chk({speed_limit_active, torque_limit_active}, 2'h1);
    chk({speed_limit_source, torque_limit_source}, 4'h9);
    setm(32'h3);
    chk(torque_cmd_source, 2'h1);
    chk({speed_limit_active, torque_limit_active}, 2'h2);
    wr(A_LE, 32'h0);
    speed_limit_enable_input <= 1'b1;
    setm(32'h3);
    chk({speed_limit_active, torque_limit_active}, 2'h2);
    speed_limit_enable_input <= 1'b0;
    torque_limit_enable_input <= 1'b1;
    setm(32'h2);
    chk({speed_limit_active, torque_limit_active}, 2'h1);
    torque_limit_enable_input <= 1'b0;
    setm(32'h2);
    chk({speed_limit_active, torque_limit_active}, 2'h0);
    {speed_select_bit1, speed_select_bit0} <= 2'b00;
    {torque_select_bit1, torque_select_bit0} <= 2'b00;
    setm(32'h4);
    chk(speed_cmd_zero, 1'b1);
    setm(32'h5);
    chk(torque_cmd_zero, 1'b1);
    setm(32'h1);
    chk({homing_allowed, position_index}, 7'h6A);
    for (int p = 0; p < 4; p++) begin
      wr(A_OP, 32'((p % 2) * 16 + p));
      repeat (4) @(posedge pclk);
      chk({analog_monitor_first_neg, analog_monitor_second_neg}, p);
      chk(position_pulse_invert, p % 2);
    end
    $display("command test done");
  endtask : t_cmds

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pulse_source_select_assigned, pulse_source_select_input, mode_select_input} = '0;
    {position_select, speed_select_bit0, speed_select_bit1, torque_select_bit0} = '0;
    {torque_select_bit1, speed_limit_enable_input, torque_limit_enable_input} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pulses();
    t_modes();
    t_cmds();
    summarize();
  end

  initial begin
    repeat (50000) @(posedge pclk);
    miscompares++;
    summarize();
  end
endmodule : pulse_command_mode_config_test
